// file: exec_pkg.sv
// constants, field layouts and state type for the return/rotate/subtract executor
// assumes a classic wishbone master on the same clock as the core
package exec_pkg;

  localparam int DATA_W = 32;
  localparam int ADR_W = 9;
  localparam int PC_W = 9;
  localparam int LVL_W = 4;
  localparam int STACK_IDX_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_N = 64;
  localparam int FADDR_W = 6;
  localparam int OP_W = 3;

  // byte addresses of the wishbone registers
  localparam logic [8:0] OFF_CMD = 9'h000;
  localparam logic [8:0] OFF_STATUS = 9'h004;
  localparam logic [8:0] OFF_WREG = 9'h008;
  localparam logic [8:0] OFF_PC = 9'h00c;
  localparam logic [8:0] OFF_STACK = 9'h010;
  localparam logic [8:0] OFF_FLAGS = 9'h014;
  // adr bit 8 set selects the file register window, index in adr[7:2]
  localparam int FILE_SEL_BIT = 8;
  localparam int FILE_IDX_LSB = 2;

  // command word layout
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_IMM_LSB = 16;

  // instruction codes in the command word
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_POP_LIT = 3'h1;
  localparam logic [2:0] OP_INT_EXIT = 3'h2;
  localparam logic [2:0] OP_SUB_EXIT = 3'h3;
  localparam logic [2:0] OP_ROTL = 3'h4;
  localparam logic [2:0] OP_SUBB = 3'h5;

  // status and flags bit positions (flags register shares c, dc, z, gie)
  localparam int STAT_BUSY = 0;
  localparam int STAT_C = 1;
  localparam int STAT_DC = 2;
  localparam int STAT_Z = 3;
  localparam int STAT_GIE = 4;
  localparam int STAT_LVL_LSB = 8;

  localparam logic [8:0] PC_STEP = 9'h001;
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [3:0] LVL_STEP = 4'h1;
  localparam logic [3:0] LVL_FULL = 4'h8;
  localparam logic [7:0] WREG_RESET = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} exec_state_t;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// file: exec_alu.sv
// rotate-left-through-carry and subtract-with-borrow-in datapath
// assumes operands come straight from core flip-flops; purely combinational
`timescale 1ns/1ps
module exec_alu (
  input wire logic [7:0] operand,
  input wire logic [7:0] wreg,
  input wire logic carry_in,
  input wire logic subtract,
  output logic [7:0] result,
  output logic carry_out,
  output logic nibble_out,
  output logic zero
);
  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    // file + ~w + c, i.e. two's complement subtract with carry as not-borrow
    sum = {1'b0, operand} + {1'b0, ~wreg} + {8'h00, carry_in};
    low = {1'b0, operand[3:0]} + {1'b0, ~wreg[3:0]} + {4'h0, carry_in};
    if (subtract) begin
      result = sum[7:0];
      carry_out = sum[8];
      nibble_out = low[4];
    end else begin
      result = {operand[6:0], carry_in};
      carry_out = operand[7];
      nibble_out = 1'b0;
    end
    zero = (result == 8'h00);
  end
endmodule // exec_alu

// file: return_rotate_subtract_exec.sv
// executor for idle, three stack returns, rotate-left and subtract-with-borrow-in
// assumes a classic wishbone master on clk; software issues one command at a time
// Notes on behaviour
// - pop_with_literal writes its 8-bit immediate into the working register.
// - pop_with_literal also loads pc from the stack top, sets global interrupt enable, 2 cycles.
// - interrupt_exit_pop loads pc from the stack top, sets the enable, 2 cycles, flags kept.
// - every return pops a non-empty stack, the level dropping by one in the same cycle that pc takes the top entry.
// - subroutine_exit_pop loads pc from the stack top in 2 cycles, enable and flags kept.
// - rotate-left puts old carry in bit 0, operand bits 6..0 in bits 7..1, bit 7 into carry.
// - rotate-left takes 1 cycle and changes only the carry among the flags.
// - for rotate and subtract, dest bit 0 writes the working register, 1 the file register.
// - subtract computes file + ~working + carry in 1 cycle and updates zero, nibble and carry.
`timescale 1ns/1ps
module return_rotate_subtract_exec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic busy_o
);
  exec_pkg::exec_state_t state_q, state_d;
  logic [31:0] cmd_q, cmd_d;
  logic [7:0] wreg_q, wreg_d;
  logic [8:0] pc_q, pc_d;
  logic c_q, c_d, dc_q, dc_d, z_q, z_d, gie_q, gie_d;
  logic [3:0] lvl_q, lvl_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] file_q [exec_pkg::FILE_N];
  logic [8:0] stack_q [exec_pkg::STACK_DEPTH];

  logic file_we, stack_we;
  logic [5:0] file_widx;
  logic [7:0] file_wval;
  logic [2:0] stack_widx, top_idx;
  logic [8:0] stack_wval, top_val;
  logic [2:0] op;
  logic dest;
  logic [5:0] faddr;
  logic [7:0] imm, operand;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z;
  logic req, wr_ok;
  logic [31:0] rd_word, wr_word;
  logic [5:0] bus_fidx;

  assign op = cmd_q[exec_pkg::CMD_OP_LSB +: exec_pkg::OP_W];
  assign dest = cmd_q[exec_pkg::CMD_DEST_BIT];
  assign faddr = cmd_q[exec_pkg::CMD_ADDR_LSB +: exec_pkg::FADDR_W];
  assign imm = cmd_q[exec_pkg::CMD_IMM_LSB +: 8];
  assign operand = file_q[faddr];
  // empty stack pops entry 0 and stays at level 0
  assign top_idx = (lvl_q == '0) ? '0 : 3'(lvl_q - exec_pkg::LVL_STEP);
  assign top_val = stack_q[top_idx];
  assign req = cyc_i & stb_i;
  // writes land on the edge where the master samples ack
  assign wr_ok = req & we_i & ack_q;
  assign bus_fidx = adr_i[exec_pkg::FILE_IDX_LSB +: exec_pkg::FADDR_W];
  assign busy_o = (state_q != exec_pkg::ST_IDLE);
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  exec_alu alu_u (
    .operand(operand),
    .wreg(wreg_q),
    .carry_in(c_q),
    .subtract(op == exec_pkg::OP_SUBB),
    .result(alu_res),
    .carry_out(alu_c),
    .nibble_out(alu_dc),
    .zero(alu_z)
  );

  // read mux
  always_comb begin
    rd_word = '0;
    if (adr_i[exec_pkg::FILE_SEL_BIT]) begin
      rd_word[7:0] = file_q[bus_fidx];
    end else begin
      case (adr_i)
        exec_pkg::OFF_CMD: rd_word = cmd_q;
        exec_pkg::OFF_STATUS: begin
          rd_word[exec_pkg::STAT_BUSY] = busy_o;
          rd_word[exec_pkg::STAT_C] = c_q;
          rd_word[exec_pkg::STAT_DC] = dc_q;
          rd_word[exec_pkg::STAT_Z] = z_q;
          rd_word[exec_pkg::STAT_GIE] = gie_q;
          rd_word[exec_pkg::STAT_LVL_LSB +: exec_pkg::LVL_W] = lvl_q;
        end
        exec_pkg::OFF_WREG: rd_word[7:0] = wreg_q;
        exec_pkg::OFF_PC: rd_word[8:0] = pc_q;
        exec_pkg::OFF_STACK: rd_word[8:0] = top_val;
        exec_pkg::OFF_FLAGS: begin
          rd_word[exec_pkg::STAT_C] = c_q;
          rd_word[exec_pkg::STAT_DC] = dc_q;
          rd_word[exec_pkg::STAT_Z] = z_q;
          rd_word[exec_pkg::STAT_GIE] = gie_q;
        end
        default: rd_word = '0;
      endcase
    end
    wr_word = exec_pkg::merge_bytes(rd_word, dat_i, sel_i);
  end

  // bus handshake: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_d = req & ~ack_q;
    dat_d = ack_d ? rd_word : dat_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // core next state
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    wreg_d = wreg_q;
    pc_d = pc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    gie_d = gie_q;
    lvl_d = lvl_q;
    file_we = 1'b0;
    file_widx = faddr;
    file_wval = alu_res;
    stack_we = 1'b0;
    stack_widx = lvl_q[2:0];
    stack_wval = wr_word[8:0];
    case (state_q)
      exec_pkg::ST_IDLE: begin
        // state writes are ignored while a command runs, so only here
        if (wr_ok) begin
          if (adr_i[exec_pkg::FILE_SEL_BIT]) begin
            file_we = 1'b1;
            file_widx = bus_fidx;
            file_wval = wr_word[7:0];
          end else begin
            case (adr_i)
              exec_pkg::OFF_CMD: begin
                cmd_d = wr_word;
                state_d = exec_pkg::ST_EXEC1;
              end
              exec_pkg::OFF_WREG: wreg_d = wr_word[7:0];
              exec_pkg::OFF_PC: pc_d = wr_word[8:0];
              exec_pkg::OFF_STACK: begin
                // a full stack refuses the push
                if (lvl_q != exec_pkg::LVL_FULL) begin
                  stack_we = 1'b1;
                  lvl_d = lvl_q + exec_pkg::LVL_STEP;
                end
              end
              exec_pkg::OFF_FLAGS: begin
                c_d = wr_word[exec_pkg::STAT_C];
                dc_d = wr_word[exec_pkg::STAT_DC];
                z_d = wr_word[exec_pkg::STAT_Z];
                gie_d = wr_word[exec_pkg::STAT_GIE];
              end
              default: state_d = exec_pkg::ST_IDLE;
            endcase
          end
        end
      end
      exec_pkg::ST_EXEC1: begin
        state_d = exec_pkg::ST_IDLE;
        case (op)
          exec_pkg::OP_POP_LIT, exec_pkg::OP_INT_EXIT, exec_pkg::OP_SUB_EXIT: begin
            state_d = exec_pkg::ST_EXEC2;
          end
          exec_pkg::OP_ROTL: begin
            pc_d = pc_q + exec_pkg::PC_STEP;
            c_d = alu_c;
            if (dest) begin
              file_we = 1'b1;
            end else begin
              wreg_d = alu_res;
            end
          end
          exec_pkg::OP_SUBB: begin
            pc_d = pc_q + exec_pkg::PC_STEP;
            c_d = alu_c;
            dc_d = alu_dc;
            z_d = alu_z;
            if (dest) begin
              file_we = 1'b1;
            end else begin
              wreg_d = alu_res;
            end
          end
          // idle and unknown codes only step pc
          default: pc_d = pc_q + exec_pkg::PC_STEP;
        endcase
      end
      exec_pkg::ST_EXEC2: begin
        state_d = exec_pkg::ST_IDLE;
        pc_d = top_val;
        if (lvl_q != '0) begin
          lvl_d = lvl_q - exec_pkg::LVL_STEP;
        end
        if (op == exec_pkg::OP_POP_LIT) begin
          wreg_d = imm;
        end
        if (op != exec_pkg::OP_SUB_EXIT) begin
          gie_d = 1'b1;
        end
      end
      default: state_d = exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= exec_pkg::ST_IDLE;
      cmd_q <= '0;
      wreg_q <= exec_pkg::WREG_RESET;
      pc_q <= exec_pkg::PC_RESET;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      gie_q <= 1'b0;
      lvl_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      wreg_q <= wreg_d;
      pc_q <= pc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      gie_q <= gie_d;
      lvl_q <= lvl_d;
    end
  end

  // file registers and stack entries, no reset: contents undefined until written
  for (genvar gi = 0; gi < exec_pkg::FILE_N; gi++) begin : g_file
    always_ff @(posedge clk) begin
      if (file_we && file_widx == 6'(gi)) begin
        file_q[gi] <= file_wval;
      end
    end
  end

  for (genvar gs = 0; gs < exec_pkg::STACK_DEPTH; gs++) begin : g_stack
    always_ff @(posedge clk) begin
      if (stack_we && stack_widx == 3'(gs)) begin
        stack_q[gs] <= stack_wval;
      end
    end
  end

  // checks
  logic [7:0] sub_ref;
  assign sub_ref = 8'(operand + ~wreg_q + {7'h00, c_q});

  a_idle_step: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && op == exec_pkg::OP_IDLE) |=>
      (pc_q == 9'($past(pc_q) + exec_pkg::PC_STEP)) && $stable(wreg_q) && $stable(c_q)
      && $stable(z_q) && $stable(gie_q) && state_q == exec_pkg::ST_IDLE)
    else $error("idle instruction changed more than pc");

  a_literal_load: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC2 && op == exec_pkg::OP_POP_LIT) |=>
      (wreg_q == $past(imm)) && gie_q && pc_q == $past(top_val))
    else $error("literal return did not load working register and pc");

  a_return_length: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && (op == exec_pkg::OP_POP_LIT
      || op == exec_pkg::OP_INT_EXIT || op == exec_pkg::OP_SUB_EXIT)) |=>
      state_q == exec_pkg::ST_EXEC2 ##1 state_q == exec_pkg::ST_IDLE)
    else $error("return did not take two cycles");

  a_int_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC2 && op == exec_pkg::OP_INT_EXIT) |=>
      gie_q && $stable(c_q) && $stable(dc_q) && $stable(z_q) && $stable(wreg_q))
    else $error("interrupt exit wrong enable or flags");

  a_stack_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC2 && lvl_q != '0) |=>
      lvl_q == 4'($past(lvl_q) - exec_pkg::LVL_STEP))
    else $error("return did not pop the stack");

  a_sub_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC2 && op == exec_pkg::OP_SUB_EXIT) |=>
      $stable(gie_q) && $stable(c_q) && $stable(z_q) && pc_q == $past(top_val))
    else $error("subroutine exit touched enable or flags");

  a_rotate_value: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && op == exec_pkg::OP_ROTL && !dest) |=>
      wreg_q == {$past(operand[6:0]), $past(c_q)} && c_q == $past(operand[7]))
    else $error("rotate result wrong");

  a_rotate_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && op == exec_pkg::OP_ROTL) |=>
      $stable(z_q) && $stable(dc_q) && $stable(gie_q) && state_q == exec_pkg::ST_IDLE)
    else $error("rotate changed other flags or ran long");

  a_dest_file: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && dest
      && (op == exec_pkg::OP_ROTL || op == exec_pkg::OP_SUBB)) |=>
      $stable(wreg_q) && file_q[$past(faddr)] == $past(alu_res))
    else $error("file destination not honoured");

  a_subtract_value: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == exec_pkg::ST_EXEC1 && op == exec_pkg::OP_SUBB && !dest) |=>
      wreg_q == $past(sub_ref) && z_q == ($past(sub_ref) == 8'h00)
      && state_q == exec_pkg::ST_IDLE)
    else $error("subtract result or zero flag wrong");

endmodule // return_rotate_subtract_exec

// file: return_rotate_subtract_exec_bench.sv
// self-checking bench for the return/rotate/subtract executor
// assumes the design answers wishbone with ack one cycle after the request, clk 40 MHz
`timescale 1ns/1ps
module return_rotate_subtract_exec_bench;
  logic clk;
  logic rst_n;
  logic cyc_i;
  logic stb_i;
  logic we_i;
  logic [8:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic busy_o;
  logic [31:0] rd;
  int failures;
  int checked;
  int seed;
  int m_w, m_pc, m_c, m_dc, m_z, m_gie, m_lvl, sum, res, op, fl;
  int stk[8];
  int files[64];

  return_rotate_subtract_exec DUT (
    .clk(clk),
    .rst_n(rst_n),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .busy_o(busy_o)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] dat);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    dat_i <= dat;
    sel_i <= 4'hf;
    do @(posedge clk); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic push();
    int v;
    v = $random(seed) & 511;
    wb(1'b1, exec_pkg::OFF_STACK, v);
    if (m_lvl < 8) begin
      stk[m_lvl] = v;
      m_lvl++;
    end
  endtask

  function automatic logic [31:0] cmd_word(int o, int d, int fa, int imm);
    return (imm << exec_pkg::CMD_IMM_LSB) | (fa << exec_pkg::CMD_ADDR_LSB) |
           (d << exec_pkg::CMD_DEST_BIT) | o;
  endfunction

  // reference behaviour of one instruction
  task automatic apply(input int o, input int d, input int fa, input int imm);
    if (o >= 1 && o <= 3) begin
      m_lvl--;
      m_pc = stk[m_lvl];
      if (o == 1) m_w = imm;
      if (o != 3) m_gie = 1;
    end else begin
      m_pc = (m_pc + 1) & 511;
    end
    if (o == 4) begin
      res = ((files[fa] << 1) | m_c) & 255;
      m_c = files[fa] >> 7;
    end
    if (o == 5) begin
      sum = files[fa] + (~m_w & 255) + m_c;
      res = sum & 255;
      m_dc = ((files[fa] & 15) + (~m_w & 15) + m_c) >> 4;
      m_c = sum >> 8;
      m_z = (res == 0);
    end
    if (o == 4 || o == 5) begin
      if (d == 1) files[fa] = res;
      else m_w = res;
    end
  endtask

  task automatic verify(input int fa);
    wb(1'b0, exec_pkg::OFF_WREG, 32'h0);
    check(rd, m_w);
    wb(1'b0, exec_pkg::OFF_PC, 32'h0);
    check(rd, m_pc);
    wb(1'b0, exec_pkg::OFF_STATUS, 32'h0);
    check(rd, (m_lvl << exec_pkg::STAT_LVL_LSB) | (m_gie << exec_pkg::STAT_GIE) |
          (m_z << exec_pkg::STAT_Z) | (m_dc << exec_pkg::STAT_DC) | (m_c << exec_pkg::STAT_C));
    wb(1'b0, 9'(256 + 4 * fa), 32'h0);
    check(rd, files[fa]);
  endtask

  // issue a command and count the cycles busy stands
  task automatic run(input int o, input int d, input int fa, input int imm);
    int n;
    wb(1'b1, exec_pkg::OFF_CMD, cmd_word(o, d, fa, imm));
    n = 0;
    @(posedge clk);
    while (busy_o === 1'b1 && n < 10) begin
      n++;
      @(posedge clk);
    end
    check(n, (o >= 1 && o <= 3) ? 2 : 1);
    apply(o, d, fa, imm);
    verify(fa);
  endtask

  initial begin
    // roughly 2000 cycles of tests expected; this leaves a wide margin
    #(25 * 20000);
    failures++;
    print_verdict();
  end

  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_n = 1'b0;
    seed = 32'h687e;
    {m_w, m_pc, m_c, m_dc, m_z, m_gie, m_lvl} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      files[i] = $random(seed) & 255;
      wb(1'b1, 9'(256 + 4 * i), files[i]);
    end
    verify(0);
    wb(1'b1, 9'h01c, 32'hffffffff);
    wb(1'b0, 9'h01c, 32'h0);
    check(rd, 32'h0);
    // nine pushes: the last one meets a full stack and is dropped
    repeat (9) push();
    wb(1'b0, exec_pkg::OFF_STACK, 32'h0);
    check(rd, stk[7]);
    verify(5);
    for (int i = 0; i < 70; i++) begin
      op = (i < 8) ? i : ($random(seed) & 7);
      if (m_lvl == 0 || (m_lvl < 8 && ($random(seed) & 1))) push();
      m_w = $random(seed) & 255;
      wb(1'b1, exec_pkg::OFF_WREG, m_w);
      fl = $random(seed) & 32'h1e;
      wb(1'b1, exec_pkg::OFF_FLAGS, fl);
      m_c = fl >> 1 & 1;
      m_dc = fl >> 2 & 1;
      m_z = fl >> 3 & 1;
      m_gie = fl >> 4 & 1;
      run(op, $random(seed) & 1, $random(seed) & 63, $random(seed) & 255);
    end
    // the earliest follow-on write lands after the return has committed, so it wins
    if (m_lvl == 0) push();
    wb(1'b1, exec_pkg::OFF_CMD, cmd_word(1, 0, 0, 8'h3c));
    wb(1'b1, exec_pkg::OFF_WREG, 32'h99);
    do wb(1'b0, exec_pkg::OFF_STATUS, 32'h0); while (rd[exec_pkg::STAT_BUSY] === 1'b1);
    apply(1, 0, 0, 8'h3c);
    m_w = 'h99;
    verify(0);
    print_verdict();
  end
endmodule // return_rotate_subtract_exec_bench
